// ==== hdl/lcdhsc_pkg.sv ====
// package: constants, command codes and state types of the lcd host command port
package lcdhsc_pkg;
  localparam int         COL_W          = 7;
  localparam int         PAGE_W         = 2;
  localparam int         LINE_W         = 5;
  localparam int         ADDR_W         = PAGE_W + COL_W;
  localparam int         MEM_DEPTH      = 512;
  localparam logic [7:0] CMD_RMW_ENTER  = 8'hE0;
  localparam logic [7:0] CMD_RMW_END    = 8'hEE;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hE2;
  localparam logic [7:0] CMD_MAP_BASE   = 8'hA0;
  localparam logic [7:0] CMD_DISP_BASE  = 8'hAE;
  localparam logic [7:0] CMD_DUTY_BASE  = 8'hA8;
  localparam logic [7:0] CMD_MASK_LSB   = 8'hFE;
  localparam logic [7:0] CMD_PAGE_BASE  = 8'hB8;
  localparam logic [7:0] CMD_PAGE_MASK  = 8'hFC;
  localparam logic [7:0] CMD_LINE_BASE  = 8'hC0;
  localparam logic [7:0] CMD_LINE_MASK  = 8'hE0;
  localparam logic [7:0] CMD_COL_MASK   = 8'h80;
  localparam logic [COL_W-1:0]  COL_RESET      = 7'h00;
  localparam logic [PAGE_W-1:0] PAGE_SOFT_RST  = 2'h3;
  localparam logic [LINE_W-1:0] LINE_CLEAR     = 5'h00;
  localparam logic [3:0]        STATUS_LOW     = 4'h0;
  localparam int                BUSY_CYCLES    = 4;
  localparam int                RESET_CYCLES   = 8;
  localparam int                CNT_W          = 4;

  typedef enum logic [1:0] {LCDHSC_IDLE, LCDHSC_BUSY, LCDHSC_INIT} lcdhsc_state_t;

  typedef struct packed {
    logic busy;
    logic segment_order_flag;
    logic display_off_flag;
    logic reset_active;
  } lcdhsc_status_t;

  typedef struct packed {
    logic              we;
    logic              re;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } lcdhsc_mem_req_t;
endpackage : lcdhsc_pkg

// ==== hdl/lcdhsc_mem.sv ====
// display memory with registered read data
`timescale 1ns/1ps
module lcdhsc_mem
  import lcdhsc_pkg::*;
(
  // clock
  input  wire logic             clk_sys,
  // request
  input  wire lcdhsc_mem_req_t  req,
  // read data
  output logic [7:0]            rdata
);
  logic [7:0] mem [MEM_DEPTH];

  // no reset on the array: contents survive reset as the display expects
  always_ff @(posedge clk_sys) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
    if (req.re) begin
      rdata <= mem[req.addr];
    end
  end
endmodule : lcdhsc_mem

// ==== hdl/lcdhsc_top.sv ====
// host command and status port of the dot-matrix lcd driver
`timescale 1ns/1ps
module lcdhsc_top
  import lcdhsc_pkg::*;
// Function
// - status byte: four flags, low nibble zero
// - cd low, rd low, wr high reads status
// - bit7 busy while executing or resetting
// - bit6 mirrors column segment mapping register
// - bit5 is inverse of display on
// - bit4 set while reset in progress
// - data write stores byte at page column
// - column increments after each data write
// - cd high, rd high, wr low writes data
// - data read returns byte from memory
// - segment only variant follows master duty
// - read gives latch, reloads latch, increments
// - E0 enters rmw, saves column, reads hold
// - EE leaves rmw, restores saved column
// - E2 clears start line, page to three
#(
  parameter bit SEGMENT_ONLY = 1'b0
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // host bus pins, asynchronous to clk_sys
  input  wire logic             cmd_data_select,
  input  wire logic             enable_read_strobe,
  input  wire logic             direction_write_strobe,
  input  wire logic [7:0]       data_in,
  output logic [7:0]            data_out,
  output logic                  data_out_en_n,
  // master timing for segment-only variant
  input  wire logic             frame_polarity_signal,
  input  wire logic             latch_clock_from_master,
  // configuration seen by the display engine
  output logic                  duty_sel,
  output logic                  display_on,
  output logic                  segment_map,
  output logic [LINE_W-1:0]     start_line,
  output logic                  frame_out
);
  typedef struct packed {
    logic [2:0]        cd_s;
    logic [2:0]        rd_s;
    logic [2:0]        wr_s;
    logic [15:0]       db_s;
    logic [2:0]        fr_s;
    logic [2:0]        cl_s;
    lcdhsc_state_t     state;
    logic [CNT_W-1:0]  cnt;
    logic [PAGE_W-1:0] page;
    logic [COL_W-1:0]  col;
    logic [COL_W-1:0]  col_saved;
    logic              rmw;
    logic              duty;
    logic              disp_on;
    logic              seg_map;
    logic [LINE_W-1:0] line;
    logic              slave_duty;
    logic              frame;
    logic [7:0]        dout;
    logic              dout_en_n;
    lcdhsc_mem_req_t   mreq;
    logic              latch_load;
    logic [7:0]        latch;
  } lcdhsc_regs_t;

  lcdhsc_regs_t   r;
  lcdhsc_regs_t   next_r;
  lcdhsc_status_t status;
  logic [7:0]     mem_rdata;
  logic           cd;
  logic           rd_n;
  logic           wr_n;
  logic [7:0]     db;
  logic           rd_fall;
  logic           wr_rise;
  logic           cl_rise;

  function automatic logic [ADDR_W-1:0] mem_addr(input logic [PAGE_W-1:0] p, input logic [COL_W-1:0] c);
    mem_addr = {p, c};
  endfunction : mem_addr

  function automatic logic cmd_is(input logic [7:0] code, input logic [7:0] base, input logic [7:0] mask);
    cmd_is = (code & mask) == base;
  endfunction : cmd_is

  lcdhsc_mem u_mem (
    .clk_sys (clk_sys),
    .req     (r.mreq),
    .rdata   (mem_rdata)
  );

  // bit [0] of each 3-bit chain, and byte [7:0] of db_s, is the first synchroniser stage and is read only by the next stage
  assign cd      = r.cd_s[1];
  assign rd_n    = r.rd_s[1];
  assign wr_n    = r.wr_s[1];
  assign db      = r.db_s[15:8];
  assign rd_fall = r.rd_s[2] & ~r.rd_s[1];
  assign wr_rise = ~r.wr_s[2] & r.wr_s[1];
  assign cl_rise = ~r.cl_s[2] & r.cl_s[1];

  always_comb begin
    status.busy               = (r.state != LCDHSC_IDLE);
    status.segment_order_flag = r.seg_map;
    status.display_off_flag   = ~r.disp_on;
    status.reset_active       = (r.state == LCDHSC_INIT);
  end

  always_comb begin
    next_r            = r;
    next_r.cd_s       = {r.cd_s[1:0], cmd_data_select};
    next_r.rd_s       = {r.rd_s[1:0], enable_read_strobe};
    next_r.wr_s       = {r.wr_s[1:0], direction_write_strobe};
    next_r.db_s       = {r.db_s[7:0], data_in};
    next_r.fr_s       = {r.fr_s[1:0], frame_polarity_signal};
    next_r.cl_s       = {r.cl_s[1:0], latch_clock_from_master};
    next_r.mreq.we    = 1'b0;
    next_r.mreq.re    = 1'b0;
    // memory read data stands one cycle after the request, so the latch loads one cycle later
    next_r.latch_load = r.mreq.re;

    if (r.latch_load) begin
      next_r.latch = mem_rdata;
    end

    // segment-only variant takes its duty from the master timing
    if (SEGMENT_ONLY && cl_rise) begin
      next_r.slave_duty = r.fr_s[2];
      next_r.frame      = r.fr_s[2];
    end

    // read cycle: drive the bus while the read strobe is low
    if (!rd_n && wr_n) begin
      next_r.dout_en_n = 1'b0;
      if (!cd) begin
        next_r.dout = {status.busy, status.segment_order_flag,
                       status.display_off_flag, status.reset_active, STATUS_LOW};
      end else if (r.dout_en_n) begin
        // snapshot at strobe start: the reload behind it stays hidden until the next read
        next_r.dout = r.latch;
      end
    end else begin
      next_r.dout_en_n = 1'b1;
    end

    unique case (r.state)
      LCDHSC_INIT: begin
        if (r.cnt == CNT_W'(RESET_CYCLES - 1)) begin
          next_r.state = LCDHSC_IDLE;
          next_r.cnt   = '0;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      LCDHSC_BUSY: begin
        if (r.cnt == CNT_W'(BUSY_CYCLES - 1)) begin
          next_r.state = LCDHSC_IDLE;
          next_r.cnt   = '0;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      LCDHSC_IDLE: begin
        // data read completes at the falling read strobe; latch reloads behind it
        if (rd_fall && cd && wr_n) begin
          next_r.mreq.re    = 1'b1;
          next_r.mreq.addr  = mem_addr(r.page, r.col);
          if (!r.rmw) begin
            next_r.col = r.col + 1'b1;
          end
          next_r.state = LCDHSC_BUSY;
        end else if (wr_rise && rd_n) begin
          next_r.state = LCDHSC_BUSY;
          if (cd) begin
            next_r.mreq.we    = 1'b1;
            next_r.mreq.addr  = mem_addr(r.page, r.col);
            next_r.mreq.wdata = db;
            next_r.col        = r.col + 1'b1;
          end else if (db == CMD_RMW_ENTER) begin
            next_r.rmw       = 1'b1;
            next_r.col_saved = r.col;
          end else if (db == CMD_RMW_END) begin
            next_r.rmw = 1'b0;
            next_r.col = r.col_saved;
          end else if (db == CMD_SOFT_RESET) begin
            next_r.line = LINE_CLEAR;
            next_r.page = PAGE_SOFT_RST;
          end else if (cmd_is(db, CMD_MAP_BASE, CMD_MASK_LSB)) begin
            next_r.seg_map = db[0];
          end else if (cmd_is(db, CMD_DISP_BASE, CMD_MASK_LSB)) begin
            next_r.disp_on = db[0];
          end else if (cmd_is(db, CMD_DUTY_BASE, CMD_MASK_LSB)) begin
            // duty register is absent on the segment-only variant
            if (!SEGMENT_ONLY) begin
              next_r.duty = db[0];
            end
          end else if (cmd_is(db, CMD_PAGE_BASE, CMD_PAGE_MASK)) begin
            next_r.page = db[PAGE_W-1:0];
          end else if (cmd_is(db, CMD_LINE_BASE, CMD_LINE_MASK)) begin
            next_r.line = db[LINE_W-1:0];
          end else if ((db & CMD_COL_MASK) == 8'h00 && !r.rmw) begin
            // column is locked against commands during read-modify-write
            next_r.col = db[COL_W-1:0];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r            <= '0;
      r.cd_s       <= 3'h7;
      r.rd_s       <= 3'h7;
      r.wr_s       <= 3'h7;
      r.state      <= LCDHSC_INIT;
      r.col        <= COL_RESET;
      r.dout_en_n  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign data_out      = r.dout;
  assign data_out_en_n = r.dout_en_n;
  assign duty_sel      = SEGMENT_ONLY ? r.slave_duty : r.duty;
  assign display_on    = r.disp_on;
  assign segment_map   = r.seg_map;
  assign start_line    = r.line;
  assign frame_out     = r.frame;
endmodule : lcdhsc_top

// ==== tb/lcdhsc_props.sv ====
// checker: bus timing and status relations of the lcd host command port
`timescale 1ns/1ps
module lcdhsc_props
  import lcdhsc_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // host pins
  input wire logic              cmd_data_select,
  input wire logic              enable_read_strobe,
  input wire logic              direction_write_strobe,
  input wire logic [7:0]        data_in,
  input wire logic [7:0]        data_out,
  input wire logic              data_out_en_n,
  // configuration
  input wire logic              display_on,
  input wire logic              segment_map,
  input wire logic [LINE_W-1:0] start_line
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_stat;
    $fell(data_out_en_n) && !cmd_data_select;
  endsequence
  sequence s_soft;
    (!cmd_data_select && !direction_write_strobe && data_in == CMD_SOFT_RESET) ##1 direction_write_strobe;
  endsequence
  property p_low;    s_stat |-> data_out[3:0] == STATUS_LOW; endproperty
  property p_map;    s_stat |-> data_out[6] == segment_map; endproperty
  property p_off;    s_stat |-> data_out[5] == !display_on; endproperty
  property p_en_on;  (!cmd_data_select && !enable_read_strobe && direction_write_strobe)[*5] |-> !data_out_en_n;
  endproperty
  property p_en_off; enable_read_strobe[*5] |-> data_out_en_n; endproperty
  property p_rst_busy; s_stat |-> !data_out[4] || data_out[7]; endproperty
  property p_init;   $fell(rst) |-> data_out_en_n && !display_on && start_line == LINE_CLEAR; endproperty
  property p_soft;   s_soft |-> ##[2:8] start_line == LINE_CLEAR; endproperty
  // config only moves in answer to a write strobe, never on its own
  property p_quiet;  direction_write_strobe[*8] |-> $stable(display_on) && $stable(segment_map) && $stable(start_line);
  endproperty
  a_low:    assert property (p_low) else $error("status low nibble not zero");
  a_map:    assert property (p_map) else $error("status map bit wrong");
  a_off:    assert property (p_off) else $error("status off bit wrong");
  a_en_on:  assert property (p_en_on) else $error("status read not driven");
  a_en_off: assert property (p_en_off) else $error("bus driven without read");
  a_init:   assert property (p_init) else $error("reset state wrong");
  a_rst_busy: assert property (p_rst_busy) else $error("reset bit without busy");
  a_soft:   assert property (p_soft) else $error("start line not cleared");
  a_quiet:  assert property (p_quiet) else $error("config changed without write");
endmodule : lcdhsc_props
bind lcdhsc_top lcdhsc_props u_props (.clk_sys(clk_sys), .rst(rst), .cmd_data_select(cmd_data_select),
  .enable_read_strobe(enable_read_strobe), .direction_write_strobe(direction_write_strobe), .data_in(data_in),
  .data_out(data_out), .data_out_en_n(data_out_en_n), .display_on(display_on), .segment_map(segment_map),
  .start_line(start_line));

// ==== tb/lcdhsc_host.sv ====
// host microcontroller model driving the parallel command bus
`timescale 1ns/1ps
module lcdhsc_host (
  // clock
  input wire logic  clk_sys,
  // device answer
  input wire logic [7:0] data_out,
  // bus pins
  output logic       cd,
  output logic       rd_n,
  output logic       wr_n,
  output logic [7:0] dq
);
  initial begin
    cd = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    dq = 8'h00;
  end
  // strobes held well past the two-stage sync in every phase
  task automatic xfer(input logic c, input logic rd, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    cd <= c;
    dq <= d;
    rd_n <= !rd;
    wr_n <= rd;
    repeat (5) @(posedge clk_sys);
    q = data_out;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    // released bus shows the inverse, not the last byte
    dq <= ~d;
  endtask : xfer
  task automatic ready(output bit ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0);
    end
  endtask : ready
endmodule : lcdhsc_host

// ==== tb/lcd_host_status_command_port_tb.sv ====
// self-checking bench for the lcd host command port
`timescale 1ns/1ps
module lcd_host_status_command_port_tb;
  import lcdhsc_pkg::*;
  logic              clk_sys;
  logic              rst;
  logic              cd;
  logic              rd_n;
  logic              wr_n;
  logic [7:0]        dq;
  logic [7:0]        data_out;
  logic [7:0]        q;
  logic              data_out_en_n;
  logic              display_on;
  logic              segment_map;
  logic [LINE_W-1:0] start_line;
  logic              duty_sel;
  logic              frame_out;
  logic              duty_sel_s;
  logic              frame_out_s;
  logic              fr;
  logic              cl;
  int                err_count;
  int                cmp_count;
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  lcdhsc_top uut (.clk_sys(clk_sys), .rst(rst), .cmd_data_select(cd), .enable_read_strobe(rd_n),
    .direction_write_strobe(wr_n), .data_in(dq), .data_out(data_out), .data_out_en_n(data_out_en_n),
    .frame_polarity_signal(fr), .latch_clock_from_master(cl), .duty_sel(duty_sel), .display_on(display_on),
    .segment_map(segment_map), .start_line(start_line), .frame_out(frame_out));
  // segment-only variant shares the host bus; the bench checks only its duty and frame outputs, the bound checker the rest
  lcdhsc_top #(.SEGMENT_ONLY(1'b1)) uut_seg (.clk_sys(clk_sys), .rst(rst), .cmd_data_select(cd),
    .enable_read_strobe(rd_n), .direction_write_strobe(wr_n), .data_in(dq), .data_out(), .data_out_en_n(),
    .frame_polarity_signal(fr), .latch_clock_from_master(cl), .duty_sel(duty_sel_s), .display_on(),
    .segment_map(), .start_line(), .frame_out(frame_out_s));
  lcdhsc_host h (.clk_sys(clk_sys), .data_out(data_out), .cd(cd), .rd_n(rd_n), .wr_n(wr_n), .dq(dq));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // every access waits for busy low first, as a real host must
  task automatic op(input logic c, input logic rd, input logic [7:0] d);
    bit ok;
    h.ready(ok);
    if (!ok) begin
      err_count++;
      finish_test();
    end
    h.xfer(c, rd, d, q);
  endtask : op
  // master timing: frame level settles before the latch clock rises
  task automatic pulse_cl(input logic f);
    @(posedge clk_sys);
    fr <= f;
    repeat (3) @(posedge clk_sys);
    cl <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cl <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : pulse_cl
  task automatic rd_at(input logic [7:0] pg, input logic [7:0] col, input logic [7:0] exp);
    op(1'b0, 1'b0, pg);
    op(1'b0, 1'b0, col);
    op(1'b1, 1'b1, 8'h00);
    op(1'b1, 1'b1, 8'h00);
    chk(q, exp);
  endtask : rd_at
  initial begin
    rst = 1'b1;
    fr = 1'b0;
    cl = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    h.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'hB0);
    op(1'b0, 1'b1, 8'h00);
    chk(q, 8'h20);
    op(1'b0, 1'b0, 8'hAF);
    op(1'b0, 1'b0, 8'hA1);
    op(1'b0, 1'b1, 8'h00);
    chk(q, 8'h40);
    op(1'b0, 1'b0, 8'hA0);
    op(1'b0, 1'b1, 8'h00);
    chk(q, 8'h00);
    $display("test status done");
    op(1'b0, 1'b0, 8'hB8);
    op(1'b0, 1'b0, 8'h00);
    op(1'b1, 1'b0, 8'h11);
    op(1'b0, 1'b0, 8'h05);
    op(1'b1, 1'b0, 8'h3C);
    op(1'b1, 1'b0, 8'h5A);
    rd_at(8'hB8, 8'h05, 8'h3C);
    op(1'b1, 1'b1, 8'h00);
    chk(q, 8'h5A);
    $display("test data done");
    op(1'b0, 1'b0, 8'h05);
    op(1'b0, 1'b0, CMD_RMW_ENTER);
    op(1'b1, 1'b1, 8'h00);
    op(1'b1, 1'b1, 8'h00);
    chk(q, 8'h3C);
    op(1'b1, 1'b0, 8'hC3);
    op(1'b0, 1'b0, CMD_RMW_END);
    op(1'b1, 1'b1, 8'h00);
    op(1'b1, 1'b1, 8'h00);
    chk(q, 8'hC3);
    $display("test rmw done");
    op(1'b0, 1'b0, 8'hA9);
    chk({7'h0, duty_sel}, 8'h01);
    pulse_cl(1'b1);
    chk({6'h0, duty_sel_s, frame_out_s}, 8'h03);
    chk({7'h0, frame_out}, 8'h00);
    pulse_cl(1'b0);
    chk({6'h0, duty_sel_s, frame_out_s}, 8'h00);
    chk({7'h0, duty_sel}, 8'h01);
    $display("test duty done");
    op(1'b0, 1'b0, 8'hCA);
    chk({3'h0, start_line}, 8'h0A);
    op(1'b0, 1'b0, CMD_SOFT_RESET);
    chk({3'h0, start_line}, 8'h00);
    op(1'b0, 1'b0, 8'h00);
    op(1'b1, 1'b0, 8'h77);
    rd_at(8'hB8, 8'h00, 8'h11);
    rd_at(8'hBB, 8'h00, 8'h77);
    $display("test soft reset done");
    finish_test();
  end
endmodule : lcd_host_status_command_port_tb
